// ---- src/tbc_tx_byte_count.v ----
// How it works
// - Sixteen 16-bit byte counts in a memory, one counter updates addressed word.
// - Line select field addresses the count memory on software loads.
// - Each DMA character fetch outside a count-load cycle increments that line's count by one.
// - Overflow is detected when all sixteen bits are zero after update.
// - Overflow emits a one-cycle transmit-finished strobe.
// - The strobe clears only the buffer-active bit of the line whose count was updated (scanner line on fetch, line select on load).
// - Cleared active bit means last character reached that transmitter.
// - Memory timeout also clears the serviced line's active bit when no finished strobe falls in the same clear cycle.
// - The strobe sets control bit 15 and status bit 0, raising the complete interrupt when mask bit 0 is set.
// - Software clearing an active bit sets no flag, no interrupt.
// - Writing zero to a count produces the finished strobe.
`include "tbc_consts.vh"

module tbc_tx_byte_count #(
    parameter LINES = 16,
    parameter WIDTH = 16
) (
    input wire i_clock,                      // 20 MHz system clock
    input wire i_rst_b,                      // Async reset, active low
    input wire i_init,                       // System initialize, active high
    input wire [`TBC_ADDR_W-1:0] i_addr,     // Register address
    input wire [15:0] i_wdata,               // Write data
    input wire i_wr,                         // Write strobe
    input wire i_rd,                         // Read strobe
    output reg [15:0] o_rdata,               // Read data, cycle after read
    input wire [3:0] i_scan_line,            // Transmitter scanner line
    input wire i_dma_fetch_cycle,            // One fetched character, pulse
    input wire i_timeout,                    // Non-existent memory, pulse
    input wire [LINES-1:0] i_active_set,     // Active bits set by start logic
    output wire [LINES-1:0] o_active,        // Buffer-active bits
    output reg o_tx_finished_pulse,          // Transmit-finished strobe
    output wire [LINES-1:0] o_clear_line_active, // Per-line clear strobes
    output wire o_irq                        // Interrupt, level
);
    // ****************************************
    // Registers
    // ****************************************
    reg [15:0] system_control_reg;
    reg [LINES-1:0] active_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_mask_reg;
    reg [15:0] ctrl_next;
    reg [LINES-1:0] active_next;
    reg [1:0] stat_next;
    reg [15:0] rdata_next;

    wire wr_ctrl = i_wr && (i_addr == `TBC_OFF_CTRL);
    wire wr_count = i_wr && (i_addr == `TBC_OFF_COUNT);
    wire wr_active = i_wr && (i_addr == `TBC_OFF_ACTIVE);
    wire wr_stat = i_wr && (i_addr == `TBC_OFF_IRQ_STAT);
    wire wr_mask = i_wr && (i_addr == `TBC_OFF_IRQ_MASK);
    wire [3:0] sel_line = system_control_reg[`TBC_LINE_MSB:`TBC_LINE_LSB];
    wire [3:0] mem_addr = wr_count ? sel_line : i_scan_line;
    wire count_zero;
    wire [WIDTH-1:0] count_word;
    wire [LINES-1:0] decode_clr;

    // ****************************************
    // Count memory
    // ****************************************
    tbc_count_mem #(
        .WIDTH(WIDTH),
        .DEPTH(LINES)
    ) u_mem (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_addr(mem_addr),
        .i_load(wr_count),
        .i_load_data(i_wdata[WIDTH-1:0]),
        .i_step(i_dma_fetch_cycle && !wr_count),
        .o_word(count_word),
        .o_zero(count_zero)
    );

    // Line latched with the update so the clear hits the line served
    reg [3:0] done_line_reg;
    reg [3:0] timeout_line_reg;
    reg timeout_reg;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            done_line_reg <= 4'h0;
            timeout_line_reg <= 4'h0;
            timeout_reg <= 1'b0;
        end else begin
            done_line_reg <= mem_addr;
            timeout_line_reg <= i_scan_line;
            timeout_reg <= i_timeout;
        end
    end

    // Strobe shares the cycle of the line clear it causes
    always @* begin
        o_tx_finished_pulse = count_zero;
    end

    // ****************************************
    // Line clear decode
    // ****************************************
    tbc_line_decode #(
        .LINES(LINES)
    ) u_dec (
        .i_line(count_zero ? done_line_reg : timeout_line_reg),
        .i_enable((count_zero || timeout_reg) && !i_init),
        .o_onehot(decode_clr)
    );
    assign o_clear_line_active = i_init ? {LINES{1'b1}} : decode_clr;

    // ****************************************
    // Next-state logic
    // ****************************************
    always @* begin
        ctrl_next = system_control_reg;
        if (wr_ctrl) begin
            ctrl_next = {system_control_reg[15] & i_wdata[15], i_wdata[14:0]};
        end
        if (count_zero) begin
            ctrl_next[`TBC_TX_DONE_BIT] = 1'b1;
        end
        active_next = (active_reg | i_active_set) & ~o_clear_line_active;
        if (wr_active) begin
            active_next = active_next & i_wdata[LINES-1:0];
        end
        stat_next = irq_stat_reg;
        if (wr_stat) begin
            stat_next = irq_stat_reg & ~i_wdata[1:0];
        end
        if (count_zero) begin
            stat_next[`TBC_IRQ_DONE_BIT] = 1'b1;
        end
        if (timeout_reg) begin
            stat_next[`TBC_IRQ_TIMEOUT_BIT] = 1'b1;
        end
        case (i_addr)
            `TBC_OFF_CTRL: rdata_next = system_control_reg;
            `TBC_OFF_COUNT: rdata_next = count_word;
            `TBC_OFF_ACTIVE: rdata_next = active_reg;
            `TBC_OFF_IRQ_STAT: rdata_next = {14'h0000, irq_stat_reg};
            `TBC_OFF_IRQ_MASK: rdata_next = {14'h0000, irq_mask_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            system_control_reg <= `TBC_CTRL_RST;
            active_reg <= `TBC_ACTIVE_RST;
            irq_stat_reg <= 2'h0;
            irq_mask_reg <= `TBC_MASK_RST;
            o_rdata <= 16'h0000;
        end else begin
            system_control_reg <= ctrl_next;
            active_reg <= active_next;
            irq_stat_reg <= stat_next;
            if (wr_mask) begin
                irq_mask_reg <= i_wdata[1:0];
            end
            o_rdata <= i_rd ? rdata_next : 16'h0000;
        end
    end

    assign o_active = active_reg;
    assign o_irq = |(irq_stat_reg & irq_mask_reg);
endmodule // tbc_tx_byte_count

// ---- src/tbc_consts.vh ----
`ifndef TBC_CONSTS_VH
`define TBC_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define TBC_ADDR_W 3
`define TBC_OFF_CTRL 3'h0
`define TBC_OFF_COUNT 3'h1
`define TBC_OFF_ACTIVE 3'h2
`define TBC_OFF_IRQ_STAT 3'h3
`define TBC_OFF_IRQ_MASK 3'h4

// ****************************************
// Field positions
// ****************************************
`define TBC_LINE_LSB 0
`define TBC_LINE_MSB 3
`define TBC_TX_DONE_BIT 15
`define TBC_IRQ_DONE_BIT 0
`define TBC_IRQ_TIMEOUT_BIT 1

// ****************************************
// Reset values
// ****************************************
`define TBC_CTRL_RST 16'h0000
`define TBC_ACTIVE_RST 16'h0000
`define TBC_MASK_RST 2'h0

`endif

// ---- src/tbc_line_decode.v ----
`include "tbc_consts.vh"

// ****************************************
// One-of-sixteen decoder with enable
// ****************************************
module tbc_line_decode #(
    parameter LINES = 16
) (
    input wire [3:0] i_line,          // Line address
    input wire i_enable,              // Decode strobe
    output wire [LINES-1:0] o_onehot  // One-hot result
);
    assign o_onehot = i_enable ? ({{(LINES-1){1'b0}}, 1'b1} << i_line) : {LINES{1'b0}};
endmodule // tbc_line_decode

// ---- src/tbc_count_mem.v ----
`include "tbc_consts.vh"

// ****************************************
// Per-line byte count memory and counter
// ****************************************
module tbc_count_mem #(
    parameter WIDTH = 16,
    parameter DEPTH = 16
) (
    input wire i_clock,               // System clock
    input wire i_rst_b,               // Async reset, active low
    input wire [3:0] i_addr,          // Word address
    input wire i_load,                // Load word from software
    input wire [WIDTH-1:0] i_load_data, // Load value
    input wire i_step,                // Increment addressed word
    output wire [WIDTH-1:0] o_word,   // Addressed word
    output reg o_zero                 // Pulse: word became zero
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    wire [WIDTH-1:0] counter_next;

    assign o_word = mem[i_addr];
    assign counter_next = i_load ? i_load_data : mem[i_addr] + {{(WIDTH-1){1'b0}}, 1'b1};

    always @(posedge i_clock) begin
        if (i_load || i_step) begin
            mem[i_addr] <= counter_next;
        end
    end

    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_zero <= 1'b0;
        end else begin
            o_zero <= (i_load || i_step) && (counter_next == {WIDTH{1'b0}});
        end
    end
endmodule // tbc_count_mem

// ---- sim/tbc_scan_model.sv ----
// ****
// Scanner and fetch side: issues N fetches for one line
// ****
module tbc_scan_model (
    input wire logic i_clock, i_rst_b, i_start, i_slow,
    input wire logic [3:0] i_line,
    input wire logic [7:0] i_count,
    output logic [3:0] o_scan_line,
    output logic o_fetch,
    output logic o_busy);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_reg;
    logic gap_reg;
    assign o_busy = left_reg != 8'h0;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            left_reg <= 8'h0;
            gap_reg <= 1'b0;
            o_fetch <= 1'b0;
            o_scan_line <= 4'h0;
        end else begin
            o_fetch <= 1'b0;
            gap_reg <= 1'b0;
            if (i_start) begin
                left_reg <= i_count;
                o_scan_line <= i_line;
            end else if (o_busy && !gap_reg) begin
                o_fetch <= 1'b1;
                left_reg <= left_reg - 8'h1;
                gap_reg <= i_slow;
            end
        end
    end
endmodule // tbc_scan_model

// ---- sim/tbc_tx_byte_count_monitor.sv ----
module tbc_monitor #(parameter LINES = 16) (
    input wire logic i_clock, i_rst_b, i_init, i_wr, i_rd, i_timeout, i_dma_fetch_cycle,
    input wire logic [2:0] i_addr,
    input wire logic [15:0] i_wdata, o_rdata,
    input wire logic [3:0] i_scan_line,
    input wire logic [LINES-1:0] i_active_set, o_active, o_clear_line_active,
    input wire logic o_tx_finished_pulse, o_irq);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    wire cnt_wr = i_wr && i_addr == 3'h1;
    wire act_wr = i_wr && i_addr == 3'h2;
    a_zero_load_pulse: assert property (cnt_wr && i_wdata == 16'h0 |=> o_tx_finished_pulse)
        else $error("zero count load gave no finish pulse");
    a_pulse_cause: assert property (o_tx_finished_pulse |-> $past(i_dma_fetch_cycle) || $past(cnt_wr))
        else $error("finish pulse without cause");
    a_pulse_decode: assert property (o_tx_finished_pulse && !i_init && $past(i_dma_fetch_cycle) && !$past(cnt_wr) |-> o_clear_line_active == 16'h1 << $past(i_scan_line))
        else $error("finish pulse cleared wrong line");
    a_init_all_clear: assert property (i_init |-> &o_clear_line_active)
        else $error("initialize did not clear all lines");
    a_clear_needs_cause: assert property (!i_init && !o_tx_finished_pulse && !$past(i_timeout) |-> o_clear_line_active == '0)
        else $error("line clear without cause");
    a_timeout_clear: assert property (i_timeout && !i_init && !i_dma_fetch_cycle && !cnt_wr |=> o_clear_line_active == 16'h1 << $past(i_scan_line) && !o_tx_finished_pulse)
        else $error("timeout clear wrong");
    a_cleared_stays: assert property (o_tx_finished_pulse && i_active_set == '0 |=> (o_active & $past(o_clear_line_active)) == '0)
        else $error("active bit not cleared after finish");
    a_sw_no_finish: assert property (act_wr && !i_dma_fetch_cycle |=> !o_tx_finished_pulse)
        else $error("software clear made finish pulse");
    a_drop_has_cause: assert property ($past(o_clear_line_active) == '0 && !$past(act_wr) && !$past(i_init) |-> ($past(o_active) & ~o_active) == '0)
        else $error("active bit dropped without cause");
    a_read_window: assert property (!$past(i_rd) |-> o_rdata == 16'h0)
        else $error("read data outside read window");
    cover property (o_tx_finished_pulse && $past(i_dma_fetch_cycle));
    cover property (o_irq);
    cover property (i_timeout);
endmodule // tbc_monitor
bind tbc_tx_byte_count tbc_monitor #(.LINES(LINES)) u_mon (.*);

// ---- sim/tbc_tx_byte_count_tb.sv ----
module tbc_tx_byte_count_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 0, i_rst_b = 0, i_init = 0, i_wr = 0, i_rd = 0, i_timeout = 0;
    logic start = 0, slow = 0, fetch, busy, o_tx_finished_pulse, o_irq;
    logic [2:0] i_addr = 0;
    logic [15:0] i_wdata = 0, i_active_set = 0, o_rdata, o_active, o_clear_line_active;
    logic [3:0] scan, line = 0;
    logic [7:0] cnt = 0;
    int err_total = 0, checked = 0, cyc = 0, pulses = 0;
    initial forever #25 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (o_tx_finished_pulse) pulses <= pulses + 1;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end
    tbc_scan_model u_scan (.i_clock, .i_rst_b, .i_start(start), .i_slow(slow), .i_line(line),
        .i_count(cnt), .o_scan_line(scan), .o_fetch(fetch), .o_busy(busy));
    tbc_tx_byte_count dut (.i_clock, .i_rst_b, .i_init, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_scan_line(scan), .i_dma_fetch_cycle(fetch), .i_timeout, .i_active_set, .o_active,
        .o_tx_finished_pulse, .o_clear_line_active, .o_irq);
    // ****
    // Bus cycles and compares
    // ****
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [15:0] d);
        i_addr <= a; i_wdata <= d; i_wr <= 1; @(posedge i_clock);
        i_wr <= 0; @(posedge i_clock);
    endtask
    task rd(input logic [2:0] a, input logic [15:0] exp);
        i_addr <= a; i_rd <= 1; @(posedge i_clock);
        i_rd <= 0; #1 chk(o_rdata, exp); @(posedge i_clock);
    endtask
    task peek(input logic [15:0] act, input int np);
        #1 chk(o_active, act); chk(pulses[15:0], np[15:0]); chk({15'h0, o_irq}, 16'h0);
        @(posedge i_clock);
    endtask
    task setact(input logic [15:0] m);
        i_active_set <= m; @(posedge i_clock); i_active_set <= 0; @(posedge i_clock);
    endtask
    task go(input logic [3:0] l, input logic [7:0] n, input logic s);
        line <= l; cnt <= n; slow <= s; start <= 1; @(posedge i_clock); start <= 0;
        repeat (200) begin
            @(posedge i_clock);
            if (!busy) break;
        end
        repeat (3) @(posedge i_clock);
    endtask
    // ****
    // Scenarios
    // ****
    task t_count;
        wr(3'h0, 16'h0005); wr(3'h4, 16'h0001); setact(16'h0020); wr(3'h1, 16'hfffd);
        go(4'h5, 8'h3, 0);
        #1 chk(o_active, 16'h0); chk(pulses[15:0], 16'h1); chk({15'h0, o_irq}, 16'h1);
        @(posedge i_clock);
        rd(3'h1, 16'h0000);
        rd(3'h0, 16'h8005);
        rd(3'h3, 16'h0001);
        wr(3'h3, 16'h0003); wr(3'h0, 16'h0009);
    endtask
    task t_abort;
        setact(16'h0200); wr(3'h1, 16'hfffb); go(4'h9, 8'h2, 1);
        rd(3'h1, 16'hfffd);
        peek(16'h0200, 1);
        wr(3'h1, 16'h0000); repeat (2) @(posedge i_clock);
        #1 chk(o_active, 16'h0); chk(pulses[15:0], 16'h2); @(posedge i_clock);
        rd(3'h3, 16'h0001);
        wr(3'h3, 16'h0003);
    endtask
    task t_sw_clear;
        setact(16'h0104); wr(3'h2, 16'hfffb);
        peek(16'h0100, 2);
        rd(3'h3, 16'h0000);
    endtask
    task t_timeout;
        setact(16'h0200); i_timeout <= 1; @(posedge i_clock); i_timeout <= 0;
        repeat (2) @(posedge i_clock);
        peek(16'h0100, 2);
        rd(3'h3, 16'h0002);
        wr(3'h4, 16'h0003); #1 chk({15'h0, o_irq}, 16'h1); @(posedge i_clock);
        wr(3'h3, 16'h0002); #1 chk({15'h0, o_irq}, 16'h0); @(posedge i_clock);
    endtask
    task t_init;
        i_init <= 1; @(posedge i_clock);
        #1 chk(o_clear_line_active, 16'hffff); @(posedge i_clock);
        i_init <= 0; @(posedge i_clock);
        peek(16'h0000, 2);
        rd(3'h7, 16'h0000);
    endtask
    task give_verdict;
        if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_clock);
        i_rst_b <= 1; @(posedge i_clock);
        t_count(); t_abort(); t_sw_clear(); t_timeout(); t_init();
        give_verdict();
    end
endmodule // tbc_tx_byte_count_tb
